// ### rtl/dacio_defines.vh
`ifndef DACIO_DEFINES_VH
`define DACIO_DEFINES_VH

// Host word and converter resolution
`define DACIO_WORD_W 16
`define DACIO_RES_W 12
// Device addresses 50..57 octal share the upper three address bits
`define DACIO_ADDR_W 6
`define DACIO_ADDR_HI 3'h5
// Converters per address, lines of control and sense
`define DACIO_NLINES 8
`define DACIO_FUNC_W 3
// Reset values
`define DACIO_SEL_RST 8'h00
`define DACIO_DAC_RST 12'h000
`define DACIO_LINES_RST 8'h00
// Two-entry data buffer
`define DACIO_BUF_DEPTH 2

`endif

// ### rtl/dacio_buf2.v
`timescale 1ns/1ps
`default_nettype none
`include "dacio_defines.vh"

// Two-entry buffer; in_ready is registered so the host handshake never waits on drain logic.
module dacio_buf2
(
    input wire clock,
    input wire sys_rst,
    input wire in_valid,
    input wire [`DACIO_RES_W-1:0] in_data,
    output reg in_ready_q,
    output wire out_valid,
    output wire [`DACIO_RES_W-1:0] out_data,
    input wire out_ready
);
    reg [`DACIO_RES_W-1:0] mem_q [0:`DACIO_BUF_DEPTH-1];
    reg wr_ptr_q;
    reg rd_ptr_q;
    reg [1:0] cnt_q;
    wire push;
    wire pop;
    reg [1:0] cnt_d;

    assign push = in_valid && in_ready_q;
    assign pop = out_valid && out_ready;
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_ptr_q];

    always @*
    begin
        cnt_d = cnt_q;
        if (push && !pop)
        begin
            cnt_d = cnt_q + 2'h1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always @(posedge clock)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
            in_ready_q <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop)
            begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            cnt_q <= cnt_d;
            in_ready_q <= (cnt_d != 2'h2);
        end
    end
endmodule // dacio_buf2

`default_nettype wire

// ### rtl/dacio_top.v
// Functional notes
// (R1) Respond only to the module's own device address, one of 50..57 octal.
// (R2) One master plus up to three slave boards share an address; master decodes.
// (R3) Eight converter-select lines, each set by its own extended select command.
// (R4) Selection holds until another select at this address or system clear.
// (R5) Buffer enable handshakes programmed transfers and a separate block-controller port.
// (R6) Data word loads the selected converter's buffer and drives it at once.
// (R7) Control command asserts exactly one of eight control lines from the function code.
// (R8) Sense command returns the level of the sense line chosen by the function code.
// (R9) Word is right-adjusted two's complement; higher bits ignored, values wrap.
// (R10) Host keeps data inside the fitted resolution's range.
// (R11) Select operand: converter 0..7 plus address; 0,1 master, 2..7 slaves.
// (R12) Host spaces transfers to one converter beyond the 20 us settling time.
// (R13) Buffer register is resolution wide and clears on system clear.
`timescale 1ns/1ps
`default_nettype none
`include "dacio_defines.vh"

module dacio_top
(
    input wire clock,
    input wire sys_rst,
    input wire [`DACIO_ADDR_W-1:0] bus_addr,
    input wire [`DACIO_FUNC_W-1:0] bus_func,
    input wire sel_cmd,
    input wire ext_cmd,
    input wire sense_cmd,
    input wire data_req,
    input wire [`DACIO_WORD_W-1:0] bus_data,
    output reg data_ack_q,
    input wire bic_req,
    input wire [`DACIO_WORD_W-1:0] bic_data,
    output reg bic_ack_q,
    input wire [2:0] addr_strap,
    input wire [`DACIO_NLINES-1:0] sense_in,
    output reg sense_result_q,
    output reg sense_valid_q,
    output reg [`DACIO_NLINES-1:0] sel_lines_q,
    output reg [`DACIO_NLINES-1:0] ext_lines_q,
    input wire load_ready,
    output reg [`DACIO_RES_W-1:0] conv_data_q,
    output reg [`DACIO_NLINES-1:0] conv_load_q,
    output reg [`DACIO_RES_W-1:0] dac0_q,
    output reg [`DACIO_RES_W-1:0] dac1_q
);
    reg [2:0] strap_meta_q;
    reg [2:0] strap_q;
    reg [`DACIO_NLINES-1:0] sense_meta_q;
    reg [`DACIO_NLINES-1:0] sense_q;
    wire addr_hit;
    wire host_take;
    wire bic_take;
    wire [`DACIO_RES_W-1:0] fill_data;
    wire buf_ready;
    wire buf_valid;
    wire [`DACIO_RES_W-1:0] buf_data;
    wire drain;
    reg [`DACIO_NLINES-1:0] sel_lines_d;
    reg [`DACIO_NLINES-1:0] ext_lines_d;
    reg sense_result_d;
    reg sense_valid_d;
    reg [`DACIO_RES_W-1:0] conv_data_d;
    reg [`DACIO_NLINES-1:0] conv_load_d;
    reg [`DACIO_RES_W-1:0] dac0_d;
    reg [`DACIO_RES_W-1:0] dac1_d;

    function [`DACIO_NLINES-1:0] one_hot;
        input [`DACIO_FUNC_W-1:0] code;
        begin
            one_hot = {{(`DACIO_NLINES-1){1'b0}}, 1'b1} << code;
        end
    endfunction

    // Strap and sense lines come from off-board, so both pass two flops first
    always @(posedge clock)
    begin
        strap_meta_q <= addr_strap;
        strap_q <= strap_meta_q;
        sense_meta_q <= sense_in;
        sense_q <= sense_meta_q;
    end

    // Slave boards carry no decode of their own; every command is gated here
    assign addr_hit = (bus_addr[5:3] == `DACIO_ADDR_HI) && (bus_addr[2:0] == strap_q); // [R1] [R2]

    // Programmed transfers win over the block controller when both ask at once
    assign host_take = data_req && addr_hit && buf_ready && !data_ack_q; // [R5]
    assign bic_take = bic_req && !host_take && buf_ready && !bic_ack_q; // [R5]

    // Only the low resolution bits are kept, so out-of-range words wrap
    assign fill_data = host_take ? bus_data[`DACIO_RES_W-1:0] : bic_data[`DACIO_RES_W-1:0]; // [R9] [R13]

    dacio_buf2 u_buf
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(host_take || bic_take),
        .in_data(fill_data),
        .in_ready_q(buf_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(load_ready)
    );

    // Words leave whenever the converter side can take one
    assign drain = buf_valid && load_ready;

    // Each ack is one cycle long and blocks a second take at the next edge,
    // which gives the host that cycle to drop its request
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            data_ack_q <= 1'b0;
            bic_ack_q <= 1'b0;
        end
        else
        begin
            data_ack_q <= host_take; // [R5]
            bic_ack_q <= bic_take; // [R5]
        end
    end

    // Command decode. A select at another address never reaches here, so
    // the converter chosen at this address holds until the next select.
    always @*
    begin
        sel_lines_d = sel_lines_q;
        ext_lines_d = `DACIO_LINES_RST;
        sense_result_d = sense_result_q;
        sense_valid_d = 1'b0;
        if (addr_hit)
        begin
            if (sel_cmd)
            begin
                sel_lines_d = one_hot(bus_func); // [R3] [R4] [R11]
            end
            if (ext_cmd)
            begin
                ext_lines_d = one_hot(bus_func); // [R7]
            end
            // Result holds between sense commands; the valid pulse marks it fresh
            if (sense_cmd)
            begin
                sense_result_d = sense_q[bus_func]; // [R8]
                sense_valid_d = 1'b1; // [R8]
            end
        end
    end

    // Selection is cleared only by system clear or by a new select here
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            sel_lines_q <= `DACIO_SEL_RST; // [R4]
        end
        else
        begin
            sel_lines_q <= sel_lines_d; // [R4]
        end
    end

    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            ext_lines_q <= `DACIO_LINES_RST;
            sense_result_q <= 1'b0;
            sense_valid_q <= 1'b0;
        end
        else
        begin
            ext_lines_q <= ext_lines_d; // [R7]
            sense_valid_q <= sense_valid_d; // [R8]
            sense_result_q <= sense_result_d; // [R8]
        end
    end

    // A word with no converter selected is drained and dropped; the host
    // gets no error for it, so software must select before it writes.
    always @*
    begin
        conv_data_d = conv_data_q;
        conv_load_d = `DACIO_LINES_RST;
        dac0_d = dac0_q;
        dac1_d = dac1_q;
        if (drain)
        begin
            conv_data_d = buf_data; // [R6]
            // Slave boards latch conv_data_q on their own strobe bit
            conv_load_d = sel_lines_q; // [R2] [R6]
            if (sel_lines_q[0])
            begin
                dac0_d = buf_data; // [R6] [R11]
            end
            if (sel_lines_q[1])
            begin
                dac1_d = buf_data; // [R6] [R11]
            end
        end
    end

    // Master converter buffers feed the converters directly, so no extra
    // command is needed once the word is in
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            dac0_q <= `DACIO_DAC_RST; // [R13]
            dac1_q <= `DACIO_DAC_RST; // [R13]
            conv_data_q <= `DACIO_DAC_RST;
            conv_load_q <= `DACIO_LINES_RST;
        end
        else
        begin
            dac0_q <= dac0_d; // [R6]
            dac1_q <= dac1_d; // [R6]
            conv_data_q <= conv_data_d;
            conv_load_q <= conv_load_d;
        end
    end
endmodule // dacio_top

`default_nettype wire

// ### dv/dacio_props.sv
`timescale 1ns/1ps
`default_nettype none
module dacio_props (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [5:0] bus_addr,
    input wire logic [2:0] bus_func,
    input wire logic sel_cmd,
    input wire logic ext_cmd,
    input wire logic sense_cmd,
    input wire logic data_req,
    input wire logic data_ack_q,
    input wire logic [2:0] addr_strap,
    input wire logic sense_valid_q,
    input wire logic [7:0] sel_lines_q,
    input wire logic [7:0] ext_lines_q,
    input wire logic [7:0] conv_load_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire hit = bus_addr == {3'h5, addr_strap};
    property p_sel; sel_cmd && hit |=> sel_lines_q == 8'h01 << $past(bus_func); endproperty
    a_sel: assert property (p_sel) else $error("select wrong");
    property p_hold; !(sel_cmd && hit) |=> $stable(sel_lines_q); endproperty
    a_hold: assert property (p_hold) else $error("select moved");
    property p_ext; ext_cmd && hit |=> ext_lines_q == 8'h01 << $past(bus_func); endproperty
    a_ext: assert property (p_ext) else $error("control wrong");
    property p_ext0; !(ext_cmd && hit) |=> ext_lines_q == 8'h00; endproperty
    a_ext0: assert property (p_ext0) else $error("stray control");
    property p_sen; sense_cmd && hit |=> sense_valid_q; endproperty
    a_sen: assert property (p_sen) else $error("no sense");
    property p_sen0; !(sense_cmd && hit) |=> !sense_valid_q; endproperty
    a_sen0: assert property (p_sen0) else $error("stray sense");
    property p_ack; data_ack_q |=> !data_ack_q; endproperty
    a_ack: assert property (p_ack) else $error("ack too long");
    property p_miss; data_req && !hit |=> !data_ack_q; endproperty
    a_miss: assert property (p_miss) else $error("foreign ack");
    property p_one; $onehot0(conv_load_q) && $onehot0(sel_lines_q); endproperty
    a_one: assert property (p_one) else $error("not one-hot");
    c_sel: cover property (sel_cmd && hit);
    c_ack: cover property (data_ack_q);
    c_sen: cover property (sense_valid_q);
endmodule // dacio_props
bind dacio_top dacio_props u_props (.clock, .sys_rst, .bus_addr, .bus_func, .sel_cmd, .ext_cmd, .sense_cmd,
    .data_req, .data_ack_q, .addr_strap, .sense_valid_q, .sel_lines_q, .ext_lines_q, .conv_load_q);
`default_nettype wire

// ### dv/dacio_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module dacio_conv_model (
    input wire logic clock,
    input wire logic stall,
    output logic load_ready = 1'b0
);
    // Stall stands for a converter still settling
    always @(posedge clock) load_ready <= !stall;
endmodule // dacio_conv_model
`default_nettype wire

// ### dv/dacio_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dacio_top_tb;
    logic clock, sys_rst, sel_cmd, ext_cmd, sense_cmd, data_req, bic_req, stall, ok;
    logic [5:0] bus_addr;
    logic [2:0] bus_func;
    logic [15:0] bus_data, bic_data;
    logic [7:0] sense_in;
    wire data_ack_q, bic_ack_q, sense_result_q, sense_valid_q, load_ready;
    wire [7:0] sel_lines_q, ext_lines_q, conv_load_q;
    wire [11:0] conv_data_q, dac0_q, dac1_q;
    int miscompares, n_compared, cyc;
    dacio_top uut (.clock, .sys_rst, .bus_addr, .bus_func, .sel_cmd, .ext_cmd, .sense_cmd, .data_req, .bus_data,
        .data_ack_q, .bic_req, .bic_data, .bic_ack_q, .addr_strap(3'h3), .sense_in,
        .sense_result_q, .sense_valid_q, .sel_lines_q, .ext_lines_q, .load_ready, .conv_data_q,
        .conv_load_q, .dac0_q, .dac1_q);
    dacio_conv_model conv (.clock, .stall, .load_ready);
    initial
    begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    task chk(logic [15:0] g, logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task step;
        @(posedge clock) #1;
    endtask
    task cmd(int k, logic [5:0] a, logic [2:0] f);
        step;
        bus_addr = a;
        bus_func = f;
        {sel_cmd, ext_cmd, sense_cmd} = 3'b100 >> k;
        step;
        {sel_cmd, ext_cmd, sense_cmd} = 3'b000;
    endtask
    // Request drops in the ack cycle so one word is never taken twice
    task tx(logic [5:0] a, logic [15:0] w, int n);
        step;
        bus_addr = a;
        bus_data = w;
        data_req = 1;
        ok = 0;
        repeat (n) if (!ok)
        begin
            step;
            ok = data_ack_q;
        end
        data_req = 0;
    endtask
    // Block controller port has no address; same one-cycle ack as the host
    task btx(logic [15:0] w, int n);
        step;
        bic_data = w;
        bic_req = 1;
        ok = 0;
        repeat (n) if (!ok)
        begin
            step;
            ok = bic_ack_q;
        end
        bic_req = 0;
    endtask
    task t_sel;
        cmd(0, 6'o52, 3'h1);
        chk(sel_lines_q, 0);
        cmd(0, 6'o53, 3'h2);
        chk(sel_lines_q, 8'h04);
        cmd(0, 6'o53, 3'h0);
        chk(sel_lines_q, 8'h01);
        $display("t_sel done");
    endtask
    task t_data;
        tx(6'o50, 16'h0111, 3);
        chk(ok, 0);
        tx(6'o53, 16'hf123, 4);
        chk(ok, 1);
        repeat (3) step;
        chk(dac0_q, 12'h123);
        stall = 1;
        repeat (2) step;
        tx(6'o53, 16'h0456, 4);
        tx(6'o53, 16'h0789, 4);
        chk(ok, 1);
        tx(6'o53, 16'h0abc, 4);
        chk(ok, 0);
        stall = 0;
        tx(6'o53, 16'h0abc, 8);
        chk(ok, 1);
        chk(dac0_q, 12'h789);
        repeat (6) step;
        chk(conv_data_q, 12'habc);
        $display("t_data done");
    endtask
    task t_cs;
        cmd(1, 6'o57, 3'h0);
        chk(ext_lines_q, 0);
        for (int f = 0; f < 8; f++)
        begin
            cmd(1, 6'o53, f[2:0]);
            chk(ext_lines_q, 8'h01 << f);
            cmd(2, 6'o53, f[2:0]);
            chk({sense_valid_q, sense_result_q}, {1'b1, sense_in[f]});
        end
        $display("t_cs done");
    endtask
    task t_bic;
        cmd(0, 6'o53, 3'h1);
        btx(16'h07ff, 4);
        chk(ok, 1);
        repeat (3) step;
        chk(dac1_q, 12'h7ff);
        chk(dac0_q, 12'habc);
        cmd(0, 6'o53, 3'h5);
        tx(6'o53, 16'h0800, 4);
        step;
        chk(conv_load_q, 8'h20);
        chk(conv_data_q, 12'h800);
        chk(dac1_q, 12'h7ff);
        $display("t_bic done");
    endtask
    task t_rst;
        sys_rst = 1;
        repeat (2) step;
        sys_rst = 0;
        step;
        chk(sel_lines_q, 0);
        chk(dac0_q, 0);
        $display("t_rst done");
    endtask
    task end_of_test;
        $display("compared %0d bad %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        {sys_rst, sel_cmd, ext_cmd, sense_cmd, data_req, bic_req, stall} = 7'b1000000;
        bus_addr = 0;
        bus_func = 0;
        bus_data = 0;
        bic_data = 0;
        sense_in = 8'h39;
        repeat (6) step;
        sys_rst = 0;
        repeat (3) step;
        t_sel;
        t_data;
        t_cs;
        t_bic;
        t_rst;
        end_of_test;
    end
endmodule // dacio_top_tb
`default_nettype wire
